// *** core/fcs_ctrl.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Reset may abort autoselect; host writes reset to leave identification mode.
// - Two unlocks plus autoselect enter identification; reads at any address then.
// - Byte program is two unlocks, set-up, then address and data.
// - Commands ignored while programming; host reissues after a hardware reset.
// - Unlocks plus 20h enter bypass; each byte is A0h then address/data.
// - In bypass only program and exit; exit is 90h then 00h.
// - Chip erase is six cycles ending in the chip-erase command.
// - Sector erase is six cycles; last carries sector address and command.
// - Host issues each extra sector write within 50 us of the last one.
module fcs_ctrl
	import fcs_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Flash pins
	output fcs_pins_t        pins,
	input  wire logic [7:0]  fl_dq_in,
	input  wire logic        fl_ready_busy
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic fcs_hit(input logic [7:0] a);
		fcs_hit = (a == OFF_CTRL) || (a == OFF_ADDR) || (a == OFF_WDATA) ||
			(a == OFF_STAT) || (a == OFF_RDATA);
	endfunction

	function automatic fcs_word_t fcs_seq(input logic [3:0] op, input logic [2:0] step,
		input logic [19:0] a, input logic [7:0] d);
		fcs_word_t w;
		logic [19:0] sa;
		sa = {a[19:SA_LSB], 13'h0000};
		w = '{ADDR_U1, CMD_U1, 1'b0};
		case (op)
			// Reset needs no unlock and any address
			// leave or abort identification
			OP_RESET: w = '{ADDR_RST, CMD_RESET, 1'b1};
			OP_BYP_PROG: w = (step == 3'd0) ? '{ADDR_RST, CMD_PROG, 1'b0} : '{a, d, 1'b1};
			OP_BYP_OUT: w = (step == 3'd0) ? '{ADDR_RST, CMD_ID, 1'b0} :
				'{ADDR_RST, CMD_BYP_X, 1'b1};
			// extra sector only by bits 19..13
			OP_SECT_ADD: w = '{sa, CMD_SECT, 1'b1};
			default: begin
				case (step)
					3'd1: w = '{ADDR_U2, CMD_U2, 1'b0};
					3'd2: begin
						case (op)
							OP_AUTOSEL: w = '{ADDR_U1, CMD_ID, 1'b1};
							OP_PROG:    w = '{ADDR_U1, CMD_PROG, 1'b0};
							OP_BYP_IN:  w = '{ADDR_U1, CMD_BYPASS, 1'b1};
							default:    w = '{ADDR_U1, CMD_ERASE, 1'b0};
						endcase
					end
					// fourth cycle carries address and data
					3'd3: w = (op == OP_PROG) ? '{a, d, 1'b1} : '{ADDR_U1, CMD_U1, 1'b0};
					3'd4: w = '{ADDR_U2, CMD_U2, 1'b0};
					3'd5: w = (op == OP_CHIP) ? '{ADDR_U1, CMD_CHIP, 1'b1} :
						'{sa, CMD_SECT, 1'b1};
					default: w = '{ADDR_U1, CMD_U1, 1'b0};
				endcase
			end
		endcase
		fcs_seq = w;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] dq_m;
	logic [7:0] dq_s;
	logic       rb_m;
	logic       rb_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_m <= 8'h00;
			dq_s <= 8'h00;
			rb_m <= 1'b1;
			rb_s <= 1'b1;
		end else begin
			dq_m <= fl_dq_in;
			dq_s <= dq_m;
			rb_m <= fl_ready_busy;
			rb_s <= rb_m;
		end
	end

	// ----------------------------------------------------------------
	// Engine state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ} fcs_st_t;

	fcs_st_t     st;
	fcs_st_t     next_st;
	logic [3:0]  op;
	logic [3:0]  next_op;
	logic [2:0]  step;
	logic [2:0]  next_step;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	fcs_pins_t   next_pins;
	logic [7:0]  rdata;
	logic [7:0]  next_rdata;
	logic [9:0]  win;
	logic [9:0]  next_win;
	logic        err;
	logic        next_err;
	fcs_word_t   w;
	fcs_word_t   w0;
	fcs_word_t   w1;
	logic        busy;

	// ----------------------------------------------------------------
	// APB decode and software registers
	// ----------------------------------------------------------------
	logic        wr_en;
	logic        rd_setup;
	logic        start;
	logic        err_clr;
	logic        cfg_wr_busy;
	logic [3:0]  wr_op;
	logic [19:0] addr_reg;
	logic [19:0] next_addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  next_wdata_reg;
	logic [31:0] next_prdata;

	assign busy    = (st != ST_IDLE);
	assign wr_en   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_op   = pwdata[3:0];
	assign start   = wr_en && (paddr == OFF_CTRL);
	assign err_clr = wr_en && (paddr == OFF_STAT) && pwdata[ST_ERR_B];
	assign cfg_wr_busy = wr_en && busy && ((paddr == OFF_ADDR) || (paddr == OFF_WDATA));
	assign pready  = penable;
	assign pslverr = psel && penable && !fcs_hit(paddr);

	always_comb begin
		next_addr_reg  = addr_reg;
		next_wdata_reg = wdata_reg;
		next_prdata    = prdata;
		// Operands are frozen while a sequence is on the pins
		if (wr_en && !busy && (paddr == OFF_ADDR))
			next_addr_reg = pwdata[19:0];
		if (wr_en && !busy && (paddr == OFF_WDATA))
			next_wdata_reg = pwdata[7:0];
		if (rd_setup) begin
			case (paddr)
				OFF_CTRL:  next_prdata = {28'h0000000, op};
				OFF_ADDR:  next_prdata = {12'h000, addr_reg};
				OFF_WDATA: next_prdata = {24'h000000, wdata_reg};
				OFF_STAT:  next_prdata = {28'h0000000, err, (win != 10'h000), rb_s, busy};
				OFF_RDATA: next_prdata = {24'h000000, rdata};
				default:   next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg  <= ADDR_RST;
			wdata_reg <= DATA_RST;
			prdata    <= 32'h00000000;
		end else begin
			addr_reg  <= next_addr_reg;
			wdata_reg <= next_wdata_reg;
			prdata    <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Bus cycle engine
	// ----------------------------------------------------------------
	assign w  = fcs_seq(op, step, addr_reg, wdata_reg);
	assign w0 = fcs_seq(wr_op, 3'd0, addr_reg, wdata_reg);
	assign w1 = fcs_seq(op, 3'(step + 3'd1), addr_reg, wdata_reg);

	always_comb begin
		next_st    = st;
		next_op    = op;
		next_step  = step;
		next_cnt   = cnt;
		next_pins  = pins;
		next_rdata = rdata;
		next_err   = err;
		next_win   = (win != 10'h000) ? 10'(win - 10'h001) : 10'h000;
		if (err_clr)
			next_err = 1'b0;
		// an order while busy is refused and flagged
		if ((start && busy) || cfg_wr_busy)
			next_err = 1'b1;
		case (st)
			ST_IDLE: begin
				if (start) begin
					next_op   = wr_op;
					next_step = 3'd0;
					// late extra sector is refused, never sent
					if (wr_op == OP_SECT_ADD && win == 10'h000) begin
						next_err = 1'b1;
						next_op  = op;
					end else if (wr_op == OP_READ) begin
						// plain read cycle at any address
						next_pins = '{1'b0, 1'b1, 1'b0, addr_reg, DATA_RST, 1'b1};
						next_cnt  = 4'(RD_CYC);
						next_st   = ST_READ;
					end else begin
						if (wr_op != OP_SECT_ADD)
							next_win = 10'h000;
						next_pins = '{1'b0, 1'b1, 1'b1, w0.addr, w0.data, 1'b0};
						next_cnt  = 4'(SU_CYC);
						next_st   = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				if (cnt == 4'h1) begin
					next_pins.we_n = 1'b0;
					next_cnt       = 4'(WP_CYC);
					next_st        = ST_STROBE;
				end else
					next_cnt = 4'(cnt - 4'h1);
			end
			ST_STROBE: begin
				if (cnt == 4'h1) begin
					next_pins.we_n = 1'b1;
					next_cnt       = 4'(WH_CYC);
					next_st        = ST_HOLD;
					// window timed from the final strobe rise
					if (w.last && (op == OP_SECT || op == OP_SECT_ADD))
						next_win = 10'(WIN_CYC);
				end else
					next_cnt = 4'(cnt - 4'h1);
			end
			ST_HOLD: begin
				if (cnt == 4'h1) begin
					if (w.last) begin
						next_pins = PINS_IDLE;
						next_st   = ST_IDLE;
					end else begin
						next_step = 3'(step + 3'd1);
						next_pins = '{1'b0, 1'b1, 1'b1, w1.addr, w1.data, 1'b0};
						next_cnt  = 4'(SU_CYC);
						next_st   = ST_SETUP;
					end
				end else
					next_cnt = 4'(cnt - 4'h1);
			end
			ST_READ: begin
				// Wait covers access time plus the two synchroniser stages
				if (cnt == 4'h1) begin
					next_rdata = dq_s;
					next_pins  = PINS_IDLE;
					next_st    = ST_IDLE;
				end else
					next_cnt = 4'(cnt - 4'h1);
			end
			default: begin
				next_pins = PINS_IDLE;
				next_st   = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st    <= ST_IDLE;
			op    <= OP_RESET;
			step  <= 3'd0;
			cnt   <= 4'h0;
			pins  <= PINS_IDLE;
			rdata <= 8'h00;
			win   <= 10'h000;
			err   <= 1'b0;
		end else begin
			st    <= next_st;
			op    <= next_op;
			step  <= next_step;
			cnt   <= next_cnt;
			pins  <= next_pins;
			rdata <= next_rdata;
			win   <= next_win;
			err   <= next_err;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic unl;
	assign unl = (op == OP_AUTOSEL) || (op == OP_PROG) || (op == OP_BYP_IN) ||
		(op == OP_CHIP) || (op == OP_SECT);

	property p_unlock1;
		$fell(pins.we_n) && unl && step == 3'd0 |-> pins.addr == ADDR_U1 && pins.dq_out == CMD_U1;
	endproperty
	a_unlock1: assert property (p_unlock1) else $error("first unlock wrong");

	property p_unlock2;
		$fell(pins.we_n) && unl && step == 3'd1 |-> pins.addr == ADDR_U2 && pins.dq_out == CMD_U2;
	endproperty
	a_unlock2: assert property (p_unlock2) else $error("second unlock wrong");

	property p_prog;
		$fell(pins.we_n) && op == OP_PROG && step == 3'd3
			|-> pins.addr == addr_reg && pins.dq_out == wdata_reg ##1 $rose(pins.we_n);
	endproperty
	a_prog: assert property (p_prog) else $error("program cycle wrong");

	property p_chip;
		$fell(pins.we_n) && op == OP_CHIP && step == 3'd5 |-> pins.dq_out == CMD_CHIP;
	endproperty
	a_chip: assert property (p_chip) else $error("chip erase final wrong");

	property p_sect;
		$fell(pins.we_n) && op == OP_SECT && step == 3'd5
			|-> pins.dq_out == CMD_SECT && pins.addr[12:0] == 13'h0000;
	endproperty
	a_sect: assert property (p_sect) else $error("sector erase final wrong");

	property p_byp;
		$fell(pins.we_n) && op == OP_BYP_PROG && step == 3'd0 |-> pins.dq_out == CMD_PROG;
	endproperty
	a_byp: assert property (p_byp) else $error("bypass program code wrong");

	property p_bypx;
		$fell(pins.we_n) && op == OP_BYP_OUT |-> pins.dq_out == (step == 3'd0 ? CMD_ID : CMD_BYP_X);
	endproperty
	a_bypx: assert property (p_bypx) else $error("bypass exit wrong");

	property p_late;
		st == ST_IDLE && start && wr_op == OP_SECT_ADD && win == 10'h000
			|=> st == ST_IDLE && err && pins.we_n [*3];
	endproperty
	a_late: assert property (p_late) else $error("late sector write sent");

	property p_frame;
		!pins.we_n |-> !pins.ce_n && pins.oe_n && !pins.dq_oe_n;
	endproperty
	a_frame: assert property (p_frame) else $error("write strobe outside frame");

	property p_read;
		// Four cycles is the read length RD_CYC
		$fell(pins.oe_n) |-> pins.dq_oe_n && pins.we_n throughout (!pins.oe_n [*4]);
	endproperty
	a_read: assert property (p_read) else $error("read cycle malformed");

endmodule

// *** core/fcs_pkg.sv ***
package fcs_pkg;
	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL  = 8'h00;
	localparam logic [7:0]  OFF_ADDR  = 8'h04;
	localparam logic [7:0]  OFF_WDATA = 8'h08;
	localparam logic [7:0]  OFF_STAT  = 8'h0C;
	localparam logic [7:0]  OFF_RDATA = 8'h10;
	localparam int          ST_BUSY_B = 0;
	localparam int          ST_RB_B   = 1;
	localparam int          ST_WIN_B  = 2;
	localparam int          ST_ERR_B  = 3;
	localparam logic [19:0] ADDR_RST  = 20'h00000;
	localparam logic [7:0]  DATA_RST  = 8'h00;

	// ----------------------------------------------------------------
	// Orders accepted in CTRL[3:0]
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_RESET    = 4'h0;
	localparam logic [3:0] OP_AUTOSEL  = 4'h1;
	localparam logic [3:0] OP_PROG     = 4'h2;
	localparam logic [3:0] OP_BYP_IN   = 4'h3;
	localparam logic [3:0] OP_BYP_PROG = 4'h4;
	localparam logic [3:0] OP_BYP_OUT  = 4'h5;
	localparam logic [3:0] OP_CHIP     = 4'h6;
	localparam logic [3:0] OP_SECT     = 4'h7;
	localparam logic [3:0] OP_SECT_ADD = 4'h8;
	localparam logic [3:0] OP_READ     = 4'h9;

	// ----------------------------------------------------------------
	// Flash command bytes and addresses
	// ----------------------------------------------------------------
	localparam logic [19:0] ADDR_U1    = 20'h00555;
	localparam logic [19:0] ADDR_U2    = 20'h002AA;
	localparam logic [7:0]  CMD_U1     = 8'hAA;
	localparam logic [7:0]  CMD_U2     = 8'h55;
	localparam logic [7:0]  CMD_RESET  = 8'hF0;
	localparam logic [7:0]  CMD_ID     = 8'h90;
	localparam logic [7:0]  CMD_PROG   = 8'hA0;
	localparam logic [7:0]  CMD_BYPASS = 8'h20;
	localparam logic [7:0]  CMD_ERASE  = 8'h80;
	localparam logic [7:0]  CMD_CHIP   = 8'h10;
	localparam logic [7:0]  CMD_SECT   = 8'h30;
	localparam logic [7:0]  CMD_BYP_X  = 8'h00;
	localparam int          SA_LSB     = 13;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS   = 100;
	localparam int SU_NS    = 50;
	localparam int WP_NS    = 50;
	localparam int WH_NS    = 50;
	localparam int ACC_NS   = 90;
	localparam int WIN_US   = 50;
	localparam int SYNC_CYC = 2;
	localparam int SU_CYC   = (SU_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC   = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WH_CYC   = (WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC   = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
	localparam int WIN_CYC  = (WIN_US * 1000) / CLK_NS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [19:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe_n;
	} fcs_pins_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  data;
		logic        last;
	} fcs_word_t;

	localparam fcs_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, ADDR_RST, DATA_RST, 1'b1};
endpackage

// *** test/fcs_flash_model.sv ***
`timescale 1ns/1ns
module fcs_flash_model
	import fcs_pkg::*;
#(
	// Identity values are arbitrary
	parameter logic [7:0] MAKER_ID = 8'h5C,
	parameter logic [7:0] PART_ID  = 8'hC4,
	parameter logic [7:0] CONT_ID  = 8'h3E,
	parameter logic [6:0] PROT_SA  = 7'h09,
	parameter int         PROG_NS  = 2000,
	parameter int         ERASE_NS = 20000,
	parameter int         WIN_NS   = 50000
)(
	// Controller pins and resolved data wire
	input  fcs_pins_t       pins,
	input  wire logic [7:0] dq_in,
	// Device outputs
	output logic [7:0]      dq_drv,
	output logic            ready_busy
);
	logic [7:0]  mem [0:1048575];
	logic [19:0] a_lat;
	logic [7:0]  rd;
	logic        busy = 1'b0;
	logic        win = 1'b0;
	logic        tog = 1'b0;
	int          step = 0;
	int          mode = 0;
	int          gen = 0;
	bit          sq [logic [6:0]];
	wire         wr_act = !pins.ce_n && !pins.we_n && pins.oe_n;

	initial begin
		ready_busy = 1'b1;
		foreach (mem[i]) mem[i] = 8'hFF;
	end

	// ----------------------------------------------------------------
	// Embedded algorithms
	// ----------------------------------------------------------------
	task automatic run(input int ns, input logic chip);
		busy = 1'b1;
		ready_busy = 1'b0;
		fork
			begin
				#(ns);
				if (chip)
					foreach (mem[i]) mem[i] = 8'hFF;
				foreach (sq[s])
					for (int i = 0; i < 8192; i++) mem[{s, i[12:0]}] = 8'hFF;
				sq.delete();
				busy = 1'b0;
				ready_busy = 1'b1;
			end
		join_none
	endtask

	task automatic add_sector(input logic [6:0] s);
		int g;
		sq[s] = 1'b1;
		win = 1'b1;
		gen++;
		g = gen;
		// timer restarts at each accepted write
		fork
			begin
				#(WIN_NS);
				if (win && g == gen) begin
					win = 1'b0;
					run(ERASE_NS, 1'b0);
				end
			end
		join_none
	endtask

	task automatic prog_byte(input logic [19:0] a, input logic [7:0] d);
		// bits only clear, success reported anyway
		mem[a] = mem[a] & d;
		run(PROG_NS, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Command interpreter
	// ----------------------------------------------------------------
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		logic u1;
		logic u2;
		u1 = a[10:0] == 11'h555 && d == CMD_U1;
		u2 = a[10:0] == 11'h2AA && d == CMD_U2;
		if (busy)
			return;
		if (win) begin
			win = d == CMD_SECT;
			if (win)
				add_sector(a[19:SA_LSB]);
			else
				sq.delete();
			return;
		end
		if (d == CMD_RESET && mode != 2) begin
			mode = 0;
			step = 0;
			return;
		end
		if (mode == 1)
			return;
		if (mode == 2) begin
			if (step == 1)
				prog_byte(a, d);
			if (step == 2 && d == CMD_BYP_X)
				mode = 0;
			step = (step == 0 && d == CMD_PROG) ? 1 : (step == 0 && d == CMD_ID) ? 2 : 0;
			return;
		end
		case (step)
			0, 4: step = u1 ? step + 1 : 0;
			1, 5: step = u2 ? step + 1 : 0;
			2: begin
				step = 0;
				if (a[10:0] == 11'h555 && d == CMD_ID)
					mode = 1;
				if (a[10:0] == 11'h555 && d == CMD_BYPASS)
					mode = 2;
				if (a[10:0] == 11'h555 && d == CMD_PROG)
					step = 3;
				if (a[10:0] == 11'h555 && d == CMD_ERASE)
					step = 4;
			end
			3: begin
				step = 0;
				prog_byte(a, d);
			end
			default: begin
				step = 0;
				if (d == CMD_SECT)
					add_sector(a[19:SA_LSB]);
				if (d == CMD_CHIP && a[10:0] == 11'h555)
					run(ERASE_NS, 1'b1);
			end
		endcase
	endtask

	// address on later fall, data on earlier rise
	always @(posedge wr_act) a_lat = pins.addr;
	always @(negedge wr_act) wr(a_lat, dq_in);
	always @(negedge pins.oe_n) tog = ~tog;

	// identification answers; released bus shows inverse
	always @* begin
		if (busy)
			rd = {1'b0, tog, 6'h00};
		else if (mode == 1)
			case (pins.addr[7:0])
				8'h00:   rd = MAKER_ID;
				8'h01:   rd = PART_ID;
				8'h03:   rd = CONT_ID;
				8'h02:   rd = (pins.addr[19:SA_LSB] == PROT_SA) ? 8'h01 : 8'h00;
				default: rd = 8'hFF;
			endcase
		else
			rd = mem[pins.addr];
		dq_drv = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
	end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb
	import fcs_pkg::*;
;
	localparam logic [19:0] PA0   = 20'h12345;
	localparam logic [19:0] PA1   = 20'h3A010;
	localparam logic [19:0] PA2   = 20'h50000;
	// Identity values are arbitrary
	localparam logic [7:0]  MAKER = 8'h5C;
	localparam logic [7:0]  PART  = 8'hC4;
	localparam logic [7:0]  CONT  = 8'h3E;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic        pready;
	logic        pslverr;
	logic        rb;
	fcs_pins_t   pins;
	logic [7:0]  dq_drv;
	wire  [7:0]  dq = pins.dq_oe_n ? dq_drv : pins.dq_out;
	int          fails = 0;
	int          n_compared = 0;

	always #50 pclk = ~pclk;

	fcs_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .fl_dq_in(dq), .fl_ready_busy(rb));
	fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART), .CONT_ID(CONT),
		.PROT_SA(PA0[19:SA_LSB])) i_flash (.pins(pins), .dq_in(dq), .dq_drv(dq_drv),
		.ready_busy(rb));

	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for a pready that never comes
		do begin
			@(posedge pclk);
		end while (!(psel && penable && pready === 1'b1));
		rdv = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
	endtask

	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 32'h0, e);
	endtask

	// Two idle polls in a row so the synchronised busy line has caught up
	task automatic wait_idle();
		int n;
		int ok;
		n = 0;
		ok = 0;
		do begin
			rd(OFF_STAT);
			ok = (rdv[ST_BUSY_B] === 1'b0 && rdv[ST_RB_B] === 1'b1) ? ok + 1 : 0;
			n++;
		end while (ok < 2 && n < 3000);
		if (n >= 3000)
			chk("idle", 32'h1, 32'h0);
	endtask

	task automatic op(input logic [3:0] code, input logic [19:0] a, input logic [7:0] d);
		wr(OFF_ADDR, {12'h000, a});
		wr(OFF_WDATA, {24'h0, d});
		wr(OFF_CTRL, {28'h0, code});
		wait_idle();
	endtask

	task automatic fread(input logic [19:0] a, input logic [7:0] exp, input string what);
		op(OP_READ, a, 8'h00);
		rd(OFF_RDATA);
		chk(what, {24'h0, exp}, rdv);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic e;
		chk("pins idle", PINS_IDLE, pins);
		rd(OFF_STAT);
		chk("status", 32'h2, rdv);
		apb(1'b0, 8'h40, 32'h0, e);
		chk("unmapped", 32'h1, {31'h0, e});
	endtask

	task automatic t_prog();
		op(OP_PROG, PA0, 8'hA5);
		fread(PA0, 8'hA5, "program");
		op(OP_PROG, PA0, 8'hFF);
		fread(PA0, 8'hA5, "no set");
		op(OP_PROG, PA0, 8'h0F);
		fread(PA0, 8'h05, "clear");
		// All ones leaves the byte as it is, so later array checks still hold
		wr(OFF_WDATA, 32'h000000FF);
		wr(OFF_CTRL, {28'h0, OP_PROG});
		wr(OFF_CTRL, {28'h0, OP_READ});
		rd(OFF_STAT);
		chk("busy refuse", 32'h1, {31'h0, rdv[ST_ERR_B]});
		wait_idle();
		wr(OFF_STAT, 32'h8);
		rd(OFF_STAT);
		chk("err clear", 32'h0, {31'h0, rdv[ST_ERR_B]});
	endtask

	task automatic t_id();
		op(OP_AUTOSEL, 20'h00000, 8'h00);
		fread(20'hFFF00, MAKER, "maker");
		fread(20'h00001, PART, "part");
		fread(20'h70003, CONT, "cont");
		fread({PA0[19:SA_LSB], 13'h0002}, 8'h01, "prot");
		fread({PA1[19:SA_LSB], 13'h0002}, 8'h00, "unprot");
		fread(20'h00000, MAKER, "maker again");
		op(OP_RESET, 20'hABCDE, 8'h00);
		fread(PA0, 8'h05, "array");
	endtask

	task automatic t_byp();
		op(OP_BYP_IN, 20'h00000, 8'h00);
		op(OP_BYP_PROG, PA1, 8'h3C);
		op(OP_BYP_PROG, PA1 + 20'h1, 8'hC3);
		op(OP_BYP_PROG, PA2, 8'h5A);
		op(OP_BYP_OUT, 20'h00000, 8'h00);
		fread(PA1, 8'h3C, "bypass 0");
		fread(PA1 + 20'h1, 8'hC3, "bypass 1");
		op(OP_AUTOSEL, 20'h00000, 8'h00);
		fread(20'h00000, MAKER, "after exit");
		op(OP_RESET, 20'h00000, 8'h00);
	endtask

	task automatic t_sect();
		op(OP_SECT, PA0, 8'h00);
		rd(OFF_STAT);
		chk("window", 32'h1, {31'h0, rdv[ST_WIN_B]});
		op(OP_RESET, 20'h00000, 8'h00);
		repeat (WIN_CYC + 100) @(posedge pclk);
		fread(PA0, 8'h05, "abort");
		op(OP_SECT, PA0, 8'h00);
		op(OP_SECT_ADD, PA1, 8'h00);
		repeat (WIN_CYC + 20) @(posedge pclk);
		wait_idle();
		fread(PA0, 8'hFF, "sector 0");
		fread(PA1, 8'hFF, "sector 1");
		fread(PA2, 8'h5A, "other");
		wr(OFF_CTRL, {28'h0, OP_SECT_ADD});
		rd(OFF_STAT);
		chk("late add", 32'h1, {31'h0, rdv[ST_ERR_B]});
		wr(OFF_STAT, 32'h8);
	endtask

	task automatic t_chip();
		op(OP_CHIP, 20'h00000, 8'h00);
		fread(PA2, 8'hFF, "chip");
	endtask

	task automatic results();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_prog();
		t_id();
		t_byp();
		t_sect();
		t_chip();
		results();
	end

	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		results();
	end
endmodule
